// ### pmt_pkg.sv
package pmt_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Byte addresses of the register words.
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h10;

	// Field positions in the control register.
	localparam int POS_PRESCALE = 0;
	localparam int POS_ON = 2;
	localparam int POS_POSTSCALE = 3;
	localparam int CTRL_W = 7;

	// Position of the match flag in the flag and mask registers.
	localparam int POS_MATCH_FLAG = 1;

	// Values after reset.
	localparam logic [CTRL_W-1:0] RST_CONTROL = 7'h00;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_PERIOD = 8'hff;
	localparam logic [3:0] RST_SCALER = 4'h0;
	localparam logic [1:0] RST_PHASE = 2'h0;

	// Last oscillator phase of an instruction cycle, and prescaler terminal counts.
	localparam logic [1:0] INSTR_LAST = 2'h3;
	localparam logic [3:0] PRE_LAST_DIV1 = 4'h0;
	localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
	localparam logic [3:0] PRE_LAST_DIV16 = 4'hf;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [5:0]
	{
		REG_NONE = 6'b000001,
		REG_CONTROL = 6'b000010,
		REG_COUNT = 6'b000100,
		REG_PERIOD = 6'b001000,
		REG_FLAGS = 6'b010000,
		REG_MASK = 6'b100000
	} pmt_reg_e;

	typedef struct packed
	{
		logic [1:0] phase;
		logic [3:0] pre;
		logic [3:0] post;
		logic [CTRL_W-1:0] ctrl;
		logic [7:0] count;
		logic [7:0] period;
		logic flag;
		logic mask;
		logic match;
		logic aw_held;
		logic [ADDR_W-1:0] awaddr;
		logic w_held;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} pmt_state_s;

endpackage

// ### pmt_timer.sv
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
// Notes on behaviour
// - Prescaler runs on instruction clock, oscillator/4.
// - Prescale select: 00 /1, 01 /4, 1x /16.
// - Postscale ratio is field value plus one.
// - Postscaler counts matches, sets match flag.
// - Count wraps to zero after matching period.
// - Period register is readable and writable.
// - Period register resets to FFh.
// - Count is read/write, reset clears it.
// - Count, control writes and reset clear scalers.
// - Control write leaves count unchanged.
// - On bit runs timer; cleared stops it.
// - Control bit 7 always reads zero.
// - Match exported as PWM and serial time base.
// - Serial clock source taken before postscaler.
module pmt_timer
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [pmt_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [pmt_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pmt_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [pmt_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic pwm_time_base,
	output logic shift_clk_src,
	output logic irq
);

	pmt_pkg::pmt_state_s st_r;
	pmt_pkg::pmt_state_s st_nxt;

	function automatic pmt_pkg::pmt_reg_e decode
	(
		input logic [pmt_pkg::ADDR_W-1:0] addr
	);
		pmt_pkg::pmt_reg_e sel;
		sel = pmt_pkg::REG_NONE;
		if (addr == pmt_pkg::OFS_CONTROL)
		begin
			sel = pmt_pkg::REG_CONTROL;
		end
		else if (addr == pmt_pkg::OFS_COUNT)
		begin
			sel = pmt_pkg::REG_COUNT;
		end
		else if (addr == pmt_pkg::OFS_PERIOD)
		begin
			sel = pmt_pkg::REG_PERIOD;
		end
		else if (addr == pmt_pkg::OFS_FLAGS)
		begin
			sel = pmt_pkg::REG_FLAGS;
		end
		else if (addr == pmt_pkg::OFS_MASK)
		begin
			sel = pmt_pkg::REG_MASK;
		end
		return sel;
	endfunction

	function automatic logic [3:0] pre_last(input logic [1:0] code);
		logic [3:0] last;
		last = pmt_pkg::PRE_LAST_DIV16;
		if (code == 2'h0)
		begin
			last = pmt_pkg::PRE_LAST_DIV1;
		end
		else if (code == 2'h1)
		begin
			last = pmt_pkg::PRE_LAST_DIV4;
		end
		return last;
	endfunction

	logic instr_tick;
	logic timer_on;
	logic pre_done;
	logic [1:0] pre_sel;
	logic [3:0] post_sel;
	logic do_write;
	logic do_read;
	pmt_pkg::pmt_reg_e wsel;
	pmt_pkg::pmt_reg_e rsel;
	logic [7:0] rval;
	logic flag_set;
	logic flag_clr;

	assign pre_sel = st_r.ctrl[pmt_pkg::POS_PRESCALE +: 2];
	assign post_sel = st_r.ctrl[pmt_pkg::POS_POSTSCALE +: 4];
	assign timer_on = st_r.ctrl[pmt_pkg::POS_ON];
	// The timer sees one instruction cycle per four oscillator cycles.
	assign instr_tick = (st_r.phase == pmt_pkg::INSTR_LAST);
	assign pre_done = instr_tick && timer_on
		&& (st_r.pre == pre_last(pre_sel));

	assign do_write = st_r.aw_held && st_r.w_held && !st_r.bvalid;
	assign wsel = decode(st_r.awaddr);
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rsel = decode(s_axi_araddr);

	always_comb
	begin
		rval = 8'h00;
		if (rsel == pmt_pkg::REG_CONTROL)
		begin
			rval = {1'b0, st_r.ctrl};
		end
		else if (rsel == pmt_pkg::REG_COUNT)
		begin
			rval = st_r.count;
		end
		else if (rsel == pmt_pkg::REG_PERIOD)
		begin
			rval = st_r.period;
		end
		else if (rsel == pmt_pkg::REG_FLAGS)
		begin
			rval[pmt_pkg::POS_MATCH_FLAG] = st_r.flag;
		end
		else if (rsel == pmt_pkg::REG_MASK)
		begin
			rval[pmt_pkg::POS_MATCH_FLAG] = st_r.mask;
		end
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.match = 1'b0;
		flag_set = 1'b0;
		st_nxt.phase = st_r.phase + 2'h1;

		// Prescaler, counter and postscaler.
		if (instr_tick && timer_on)
		begin
			if (pre_done)
			begin
				st_nxt.pre = pmt_pkg::RST_SCALER;
			end
			else
			begin
				st_nxt.pre = st_r.pre + 4'h1;
			end
		end
		if (pre_done)
		begin
			if (st_r.count == st_r.period)
			begin
				st_nxt.count = 8'h00;
				st_nxt.match = 1'b1;
				if (st_r.post == post_sel)
				begin
					st_nxt.post = pmt_pkg::RST_SCALER;
					flag_set = 1'b1;
				end
				else
				begin
					st_nxt.post = st_r.post + 4'h1;
				end
			end
			else
			begin
				st_nxt.count = st_r.count + 8'h01;
			end
		end

		// Write address and data are taken independently.
		if (s_axi_awvalid && s_axi_awready)
		begin
			st_nxt.aw_held = 1'b1;
			st_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			st_nxt.w_held = 1'b1;
			st_nxt.wdata = s_axi_wdata[7:0];
			st_nxt.wstrb0 = s_axi_wstrb[0];
		end
		if (do_write)
		begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = pmt_pkg::RESP_OKAY;
			if (wsel == pmt_pkg::REG_NONE)
			begin
				st_nxt.bresp = pmt_pkg::RESP_SLVERR;
			end
			else if (st_r.wstrb0)
			begin
				if (wsel == pmt_pkg::REG_CONTROL)
				begin
					// Count keeps its value here.
					st_nxt.ctrl = st_r.wdata[pmt_pkg::CTRL_W-1:0];
					st_nxt.pre = pmt_pkg::RST_SCALER;
					st_nxt.post = pmt_pkg::RST_SCALER;
				end
				else if (wsel == pmt_pkg::REG_COUNT)
				begin
					// A software write beats a same-cycle increment.
					st_nxt.count = st_r.wdata;
					st_nxt.pre = pmt_pkg::RST_SCALER;
					st_nxt.post = pmt_pkg::RST_SCALER;
				end
				else if (wsel == pmt_pkg::REG_PERIOD)
				begin
					st_nxt.period = st_r.wdata;
				end
				else if (wsel == pmt_pkg::REG_MASK)
				begin
					st_nxt.mask = st_r.wdata[pmt_pkg::POS_MATCH_FLAG];
				end
			end
		end
		if (st_r.bvalid && s_axi_bready)
		begin
			st_nxt.bvalid = 1'b0;
		end

		// Reads return the value seen at the address handshake.
		if (do_read)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rval;
			st_nxt.rresp = (rsel == pmt_pkg::REG_NONE)
				? pmt_pkg::RESP_SLVERR : pmt_pkg::RESP_OKAY;
		end
		else if (st_r.rvalid && s_axi_rready)
		begin
			st_nxt.rvalid = 1'b0;
		end

		// Reading the flag register clears it, but a same-cycle flag set from the postscaler wins.
		flag_clr = do_read && (rsel == pmt_pkg::REG_FLAGS);
		if (flag_set)
		begin
			st_nxt.flag = 1'b1;
		end
		else if (flag_clr)
		begin
			st_nxt.flag = 1'b0;
		end

		if (!aresetn)
		begin
			st_nxt = '0;
			st_nxt.phase = pmt_pkg::RST_PHASE;
			st_nxt.pre = pmt_pkg::RST_SCALER;
			st_nxt.post = pmt_pkg::RST_SCALER;
			st_nxt.ctrl = pmt_pkg::RST_CONTROL;
			st_nxt.count = pmt_pkg::RST_COUNT;
			st_nxt.period = pmt_pkg::RST_PERIOD;
		end
	end

	always_ff @(posedge aclk)
	begin
		st_r <= st_nxt;
	end

	assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
	assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rresp = st_r.rresp;
	assign s_axi_rdata = {24'h000000, st_r.rdata};
	assign pwm_time_base = st_r.match;
	assign shift_clk_src = st_r.match;
	assign irq = st_r.flag && st_r.mask;

endmodule

// ### pmt_properties.sv
`timescale 1ns/1ns
module pmt_properties
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_awvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pwm_time_base,
	input wire logic shift_clk_src,
	input wire logic irq
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b lost");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r lost");
	a_rdata_byte: assert property (s_axi_rvalid |->
		s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
	a_w_refused: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("w taken");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("no read answer");
	a_serial_src: assert property (shift_clk_src == pwm_time_base)
		else $error("shift source differs");
	a_match_gap: assert property (pwm_time_base
		|=> !pwm_time_base [*3]) else $error("match too soon");
	a_irq_sticky: assert property (irq && !s_axi_arvalid
		&& !s_axi_awvalid && !$past(s_axi_awvalid) |=> irq)
		else $error("irq dropped");
endmodule
bind pmt_timer pmt_properties u_props (.*);

// ### period_match_timer8_test.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
	n_mismatch++; $display("ERROR %0t mismatch", $time); end end
module period_match_timer8_test;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic pwm_time_base, shift_clk_src, irq;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int n_mismatch, n_compared, k;
	pmt_timer uut (.*);
	initial
	begin
		aclk = 0;
		forever #50 aclk = ~aclk;
	end
	task automatic bus(input bit w, input logic [7:0] a, input logic [7:0] d);
		bit ha, hw, hr;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (k = 0; k < 60; k++)
		begin
			@(negedge aclk);
			if (w ? s_axi_bvalid : s_axi_rvalid)
				break;
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			hr = s_axi_arvalid && s_axi_arready;
			@(posedge aclk);
			if (ha)
				s_axi_awvalid <= 0;
			if (hw)
				s_axi_wvalid <= 0;
			if (hr)
				s_axi_arvalid <= 0;
		end
		q = s_axi_rdata;
		r = w ? s_axi_bresp : s_axi_rresp;
		@(posedge aclk);
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		@(negedge aclk);
	endtask
	// Returns the number of cycles until the next match pulse.
	task automatic pw(output int t);
		for (t = 1; t < 3000; t++)
		begin
			@(negedge aclk);
			if (pwm_time_base === 1'b1)
				break;
		end
	endtask
	task automatic t_reset;
		bus(0, pmt_pkg::OFS_COUNT, 8'h0);
		`CHK(q, 32'h0)
		bus(0, pmt_pkg::OFS_PERIOD, 8'h0);
		`CHK(q, 32'hff)
	endtask
	task automatic t_regs;
		bus(1, pmt_pkg::OFS_PERIOD, 8'h5a);
		`CHK(r, pmt_pkg::RESP_OKAY)
		bus(0, pmt_pkg::OFS_PERIOD, 8'h0);
		`CHK(q, 32'h5a)
		bus(1, pmt_pkg::OFS_CONTROL, 8'hfb);
		bus(0, pmt_pkg::OFS_CONTROL, 8'h0);
		`CHK(q, 32'h7b)
		// Stop the timer so that the count must hold its written value.
		bus(1, pmt_pkg::OFS_CONTROL, 8'h78);
		bus(1, pmt_pkg::OFS_COUNT, 8'h37);
		repeat (100) @(negedge aclk);
		bus(1, pmt_pkg::OFS_CONTROL, 8'h78);
		bus(0, pmt_pkg::OFS_COUNT, 8'h0);
		`CHK(q, 32'h37)
		bus(0, 8'h20, 8'h0);
		`CHK(r, pmt_pkg::RESP_SLVERR)
		`CHK(q, 32'h0)
	endtask
	task automatic t_scale;
		int dv[4] = '{1, 4, 16, 16};
		int t;
		bus(1, pmt_pkg::OFS_PERIOD, 8'h03);
		for (int c = 0; c < 4; c++)
		begin
			bus(1, pmt_pkg::OFS_COUNT, 8'h0);
			bus(1, pmt_pkg::OFS_CONTROL, 8'h04 | c[7:0]);
			pw(t);
			pw(t);
			`CHK(t, 16 * dv[c])
		end
	endtask
	task automatic t_post;
		int s[3] = '{0, 2, 15};
		int n;
		bus(1, pmt_pkg::OFS_PERIOD, 8'h01);
		for (int i = 0; i < 3; i++)
		begin
			bus(1, pmt_pkg::OFS_CONTROL, 8'h0);
			bus(1, pmt_pkg::OFS_COUNT, 8'h0);
			bus(0, pmt_pkg::OFS_FLAGS, 8'h0);
			bus(1, pmt_pkg::OFS_MASK, 8'h02);
			bus(1, pmt_pkg::OFS_CONTROL, {1'b0, s[i][3:0], 3'h4});
			for (n = 0; n < 40; )
			begin
				@(negedge aclk);
				if (pwm_time_base === 1'b1)
					n++;
				if (irq === 1'b1)
					break;
			end
			`CHK(n, s[i] + 1)
		end
		repeat (40) @(negedge aclk);
		`CHK(irq, 1'b1)
		bus(1, pmt_pkg::OFS_CONTROL, 8'h0);
		bus(1, pmt_pkg::OFS_MASK, 8'h0);
		`CHK(irq, 1'b0)
		bus(0, pmt_pkg::OFS_FLAGS, 8'h0);
		`CHK(q, 32'h2)
		bus(1, pmt_pkg::OFS_MASK, 8'h02);
		`CHK(irq, 1'b0)
	endtask
	task print_verdict;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#2000000;
		n_mismatch++;
		print_verdict;
	end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 0;
		s_axi_wdata = 0;
		s_axi_wstrb = 4'hf;
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_regs;
		t_scale;
		t_post;
		print_verdict;
	end
endmodule
